/* shared/ctb_defines.svh */
// Offsets, field positions, non-volatile defaults and timing counts of the tuning bank
`ifndef CTB_DEFINES_SVH
`define CTB_DEFINES_SVH

`define CTB_OFS_THRESHOLDS 8'hd9
`define CTB_OFS_MAX_CURRENT 8'hda
`define CTB_OFS_BOOT_CODE 8'hdb
`define CTB_OFS_FREQ_SOFT 8'hdc
`define CTB_OFS_SLEW_MODES 8'hdd
`define CTB_OFS_RAMP 8'hde

`define CTB_MASK_THRESHOLDS 8'h77
`define CTB_MASK_MAX_CURRENT 8'hff
`define CTB_MASK_BOOT_CODE 8'hff
`define CTB_MASK_FREQ_SOFT 8'hf3
`define CTB_MASK_SLEW_MODES 8'hff
`define CTB_MASK_RAMP 8'h07

`define CTB_NVM_THRESHOLDS 8'h77
`define CTB_NVM_MAX_CURRENT 8'h78
`define CTB_NVM_BOOT_CODE 8'h97
`define CTB_NVM_FREQ_SOFT 8'h20
`define CTB_NVM_SLEW_MODES 8'h89
`define CTB_NVM_RAMP 8'h06

`define CTB_USR_HI 6
`define CTB_USR_LO 4
`define CTB_OSR_HI 2
`define CTB_OSR_LO 0
`define CTB_FSW_HI 7
`define CTB_FSW_LO 4
`define CTB_RISE_HI 1
`define CTB_RISE_LO 0
`define CTB_SLEW_HI 2
`define CTB_SLEW_LO 0
`define CTB_RAMP_HI 2
`define CTB_RAMP_LO 0
`define CTB_BIT_VID_TABLE 7
`define CTB_BIT_PAIRING 6
`define CTB_BIT_SHEDDING 4
`define CTB_BIT_ZERO_LL 3
`define CTB_CODE_OFF 3'h7

`define CTB_FAST_SLEW_ADD 10'h088
`define CTB_SETTLE_CYCLES 2'h3

`endif

/* shared/ctb_pkg.sv */
// Types shared by the tuning bank modules
package ctb_pkg;

	typedef enum logic [1:0] {
		CTB_SETTLE = 2'h0,
		CTB_APPLY = 2'h1,
		CTB_RUN = 2'h3
	} ctb_phase_type;

	typedef logic [7:0] ctb_byte_type;

	// Keeps only writable bits; reserved bits stay zero
	function automatic ctb_byte_type ctb_masked(input ctb_byte_type value, input ctb_byte_type mask);
		ctb_masked = value & mask;
	endfunction

endpackage

/* rtl/ctb_decode.sv */
// Translation of stored setting codes into physical quantities
`timescale 1ns/1ps
`default_nettype none
`include "ctb_defines.svh"

module ctb_decode import ctb_pkg::*; #(
	parameter logic [11:0] VID_NEW_BASE_MV = 12'h1f4,
	parameter logic [11:0] VID_NEW_STEP_MV = 12'h00a,
	parameter logic [11:0] VID_OLD_BASE_MV = 12'h0fa,
	parameter logic [11:0] VID_OLD_STEP_MV = 12'h005
) (
	// Stored settings
	input wire logic [7:0] thresholds,
	input wire logic [7:0] boot_code,
	input wire logic [7:0] freq_soft,
	input wire logic [7:0] slew_modes,
	input wire logic [7:0] ramp,
	input wire logic fast_slew_enable,
	// Physical values
	output logic [7:0] undershoot_mv,
	output logic undershoot_on,
	output logic [7:0] overshoot_mv,
	output logic overshoot_on,
	output logic [9:0] freq_khz,
	output logic [9:0] slew_rate,
	output logic [9:0] soft_start_slew,
	output logic [7:0] ramp_mv,
	output logic [11:0] boot_mv
);

	function automatic logic [7:0] cut_mv(input logic [2:0] code, input logic is_over);
		case (code)
			3'h0: cut_mv = is_over ? 8'h1e : 8'h14;
			3'h1: cut_mv = is_over ? 8'h28 : 8'h1e;
			3'h2: cut_mv = 8'h3c;
			3'h3: cut_mv = 8'h50;
			3'h4: cut_mv = 8'h64;
			3'h5: cut_mv = 8'h78;
			3'h6: cut_mv = 8'h8c;
			default: cut_mv = 8'h00;
		endcase
	endfunction

	logic [2:0] slew_code;
	logic [9:0] base_slew;
	logic [11:0] vid_base;
	logic [11:0] vid_step;

	always_comb begin
		undershoot_mv = cut_mv(thresholds[`CTB_USR_HI:`CTB_USR_LO], 1'b0);
		undershoot_on = thresholds[`CTB_USR_HI:`CTB_USR_LO] != `CTB_CODE_OFF;
		overshoot_mv = cut_mv(thresholds[`CTB_OSR_HI:`CTB_OSR_LO], 1'b1);
		overshoot_on = thresholds[`CTB_OSR_HI:`CTB_OSR_LO] != `CTB_CODE_OFF;

		// Codes 8 to 14 fill the 50 kHz gaps; code 15 repeats 1000 kHz
		case (freq_soft[`CTB_FSW_HI:`CTB_FSW_LO])
			4'h0: freq_khz = 10'h12c;
			4'h1: freq_khz = 10'h190;
			4'h2: freq_khz = 10'h1f4;
			4'h3: freq_khz = 10'h258;
			4'h4: freq_khz = 10'h2bc;
			4'h5: freq_khz = 10'h320;
			4'h6: freq_khz = 10'h384;
			4'h7: freq_khz = 10'h3e8;
			4'h8: freq_khz = 10'h15e;
			4'h9: freq_khz = 10'h1c2;
			4'ha: freq_khz = 10'h226;
			4'hb: freq_khz = 10'h28a;
			4'hc: freq_khz = 10'h2ee;
			4'hd: freq_khz = 10'h352;
			4'he: freq_khz = 10'h3b6;
			default: freq_khz = 10'h3e8;
		endcase

		// Slew in units of 10 uV/us; unlisted code 3 sits midway
		slew_code = slew_modes[`CTB_SLEW_HI:`CTB_SLEW_LO];
		case (slew_code)
			3'h0: base_slew = 10'h022;
			3'h1: base_slew = 10'h044;
			3'h2: base_slew = 10'h066;
			3'h3: base_slew = 10'h088;
			3'h4: base_slew = 10'h0aa;
			3'h5: base_slew = 10'h0cc;
			3'h6: base_slew = 10'h0ee;
			default: base_slew = 10'h112;
		endcase
		slew_rate = fast_slew_enable ? base_slew + `CTB_FAST_SLEW_ADD : base_slew;
		soft_start_slew = slew_rate >> freq_soft[`CTB_RISE_HI:`CTB_RISE_LO];

		case (ramp[`CTB_RAMP_HI:`CTB_RAMP_LO])
			3'h0: ramp_mv = 8'h14;
			3'h1: ramp_mv = 8'h28;
			3'h2: ramp_mv = 8'h3c;
			3'h3: ramp_mv = 8'h50;
			3'h4: ramp_mv = 8'h64;
			3'h5: ramp_mv = 8'h78;
			3'h6: ramp_mv = 8'h96;
			default: ramp_mv = 8'hc8;
		endcase

		vid_base = slew_modes[`CTB_BIT_VID_TABLE] ? VID_OLD_BASE_MV : VID_NEW_BASE_MV;
		vid_step = slew_modes[`CTB_BIT_VID_TABLE] ? VID_OLD_STEP_MV : VID_NEW_STEP_MV;
		if (boot_code == 8'h00) begin
			boot_mv = 12'h000;
		end else begin
			boot_mv = vid_base + 12'((boot_code - 8'h01) * vid_step);
		end
	end

endmodule // ctb_decode
`default_nettype wire

/* rtl/ctb_config_bank.sv */
// Converter tuning register bank with strap or non-volatile defaults
`timescale 1ns/1ps
`default_nettype none
`include "ctb_defines.svh"

module ctb_config_bank import ctb_pkg::*; #(
	parameter logic [11:0] VID_NEW_BASE_MV = 12'h1f4,
	parameter logic [11:0] VID_NEW_STEP_MV = 12'h00a,
	parameter logic [11:0] VID_OLD_BASE_MV = 12'h0fa,
	parameter logic [11:0] VID_OLD_STEP_MV = 12'h005
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Strap pins, already resolved to byte codes
	input wire logic use_nvm_defaults,
	input wire logic [7:0] strap_thresholds,
	input wire logic [7:0] freq_current_strap_pin_max_current_amps,
	input wire logic [7:0] freq_current_strap_pin_freq,
	input wire logic [7:0] strap_boot_code,
	input wire logic [7:0] strap_slew_modes,
	input wire logic [7:0] current_limit_ramp_strap_pin,
	// Neighbouring fast-slew control
	input wire logic fast_slew_enable,
	// Command port from the serial transport
	input wire logic [7:0] cmd_code,
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic cmd_hit,
	output logic config_ready,
	// Register fields
	output logic [2:0] undershoot_cut_threshold,
	output logic [2:0] overshoot_cut_threshold,
	output logic [7:0] max_current_amps,
	output logic [7:0] boot_voltage_code,
	output logic [3:0] switching_frequency_select,
	output logic [1:0] soft_start_rise_scale,
	output logic vid_table_select,
	output logic interleave_pairing_select,
	output logic phase_shedding_enable,
	output logic zero_load_line_select,
	output logic [2:0] ramp_amplitude_select,
	// Decoded physical values
	output logic [7:0] undershoot_mv,
	output logic undershoot_on,
	output logic [7:0] overshoot_mv,
	output logic overshoot_on,
	output logic [9:0] freq_khz,
	output logic [9:0] slew_rate,
	output logic [9:0] soft_start_slew,
	output logic [7:0] ramp_mv,
	output logic [11:0] boot_mv
);

	typedef struct packed {
		ctb_phase_type phase;
		logic [1:0] settle;
		logic [48:0] strap_s1;
		logic [48:0] strap_s2;
		logic [7:0] thresholds;
		logic [7:0] max_current;
		logic [7:0] boot_code;
		logic [7:0] freq_soft;
		logic [7:0] slew_modes;
		logic [7:0] ramp;
		logic [7:0] rdata;
		logic rvalid;
		logic hit;
		logic ready;
		logic [7:0] usr_mv;
		logic usr_on;
		logic [7:0] osr_mv;
		logic osr_on;
		logic [9:0] freq;
		logic [9:0] slew;
		logic [9:0] soft_slew;
		logic [7:0] ramp_pp;
		logic [11:0] boot_target;
	} ctb_state_type;

	ctb_state_type cur;
	ctb_state_type next_cur;

	logic [7:0] dec_usr_mv;
	logic dec_usr_on;
	logic [7:0] dec_osr_mv;
	logic dec_osr_on;
	logic [9:0] dec_freq;
	logic [9:0] dec_slew;
	logic [9:0] dec_soft_slew;
	logic [7:0] dec_ramp;
	logic [11:0] dec_boot;

	// Decode runs on stored values, so physical outputs trail by one cycle
	ctb_decode #(
		.VID_NEW_BASE_MV(VID_NEW_BASE_MV),
		.VID_NEW_STEP_MV(VID_NEW_STEP_MV),
		.VID_OLD_BASE_MV(VID_OLD_BASE_MV),
		.VID_OLD_STEP_MV(VID_OLD_STEP_MV)
	) u_decode (
		.thresholds(cur.thresholds),
		.boot_code(cur.boot_code),
		.freq_soft(cur.freq_soft),
		.slew_modes(cur.slew_modes),
		.ramp(cur.ramp),
		.fast_slew_enable(fast_slew_enable),
		.undershoot_mv(dec_usr_mv),
		.undershoot_on(dec_usr_on),
		.overshoot_mv(dec_osr_mv),
		.overshoot_on(dec_osr_on),
		.freq_khz(dec_freq),
		.slew_rate(dec_slew),
		.soft_start_slew(dec_soft_slew),
		.ramp_mv(dec_ramp),
		.boot_mv(dec_boot)
	);

	// Synchronised strap view: nvm select on top, then six bytes
	logic s_nvm;
	logic [7:0] s_thr;
	logic [7:0] s_max_current_amps;
	logic [7:0] s_freq;
	logic [7:0] s_boot;
	logic [7:0] s_slew;
	logic [7:0] s_ramp;
	logic wr_ok;

	assign {s_nvm, s_thr, s_max_current_amps, s_freq, s_boot, s_slew, s_ramp} = cur.strap_s2;
	assign wr_ok = cmd_write && cur.phase == CTB_RUN;

	always_comb begin
		next_cur = cur;
		// Straps may sit in another domain; first stage feeds only the second
		next_cur.strap_s1 = {use_nvm_defaults, strap_thresholds, freq_current_strap_pin_max_current_amps,
			freq_current_strap_pin_freq, strap_boot_code, strap_slew_modes,
			current_limit_ramp_strap_pin};
		next_cur.strap_s2 = cur.strap_s1;
		next_cur.rvalid = 1'b0;
		next_cur.hit = 1'b0;

		case (cur.phase)
			CTB_SETTLE: begin
				// Wait until synchronised strap levels are stable
				next_cur.settle = cur.settle + 2'h1;
				if (cur.settle == `CTB_SETTLE_CYCLES) begin
					next_cur.phase = CTB_APPLY;
				end
			end
			CTB_APPLY: begin
				if (s_nvm) begin
					next_cur.thresholds = `CTB_NVM_THRESHOLDS;
					next_cur.max_current = `CTB_NVM_MAX_CURRENT;
					next_cur.boot_code = `CTB_NVM_BOOT_CODE;
					next_cur.freq_soft = `CTB_NVM_FREQ_SOFT;
					next_cur.slew_modes = `CTB_NVM_SLEW_MODES;
					next_cur.ramp = `CTB_NVM_RAMP;
				end else begin
					next_cur.thresholds = ctb_masked(s_thr, `CTB_MASK_THRESHOLDS);
					next_cur.max_current = s_max_current_amps;
					next_cur.boot_code = s_boot;
					next_cur.freq_soft = ctb_masked(s_freq, `CTB_MASK_FREQ_SOFT);
					next_cur.slew_modes = s_slew;
					next_cur.ramp = ctb_masked(s_ramp, `CTB_MASK_RAMP);
				end
				next_cur.phase = CTB_RUN;
			end
			CTB_RUN: begin
				next_cur.phase = CTB_RUN;
			end
			default: begin
				next_cur.phase = CTB_SETTLE;
			end
		endcase

		// Host writes override whichever default was loaded
		if (wr_ok) begin
			if (cmd_code == `CTB_OFS_THRESHOLDS) begin
				next_cur.thresholds = ctb_masked(cmd_wdata, `CTB_MASK_THRESHOLDS);
			end else if (cmd_code == `CTB_OFS_MAX_CURRENT) begin
				next_cur.max_current = ctb_masked(cmd_wdata, `CTB_MASK_MAX_CURRENT);
			end else if (cmd_code == `CTB_OFS_BOOT_CODE) begin
				next_cur.boot_code = ctb_masked(cmd_wdata, `CTB_MASK_BOOT_CODE);
			end else if (cmd_code == `CTB_OFS_FREQ_SOFT) begin
				next_cur.freq_soft = ctb_masked(cmd_wdata, `CTB_MASK_FREQ_SOFT);
			end else if (cmd_code == `CTB_OFS_SLEW_MODES) begin
				// Bit 5 is stored for read-back but steers nothing
				next_cur.slew_modes = ctb_masked(cmd_wdata, `CTB_MASK_SLEW_MODES);
			end else if (cmd_code == `CTB_OFS_RAMP) begin
				next_cur.ramp = ctb_masked(cmd_wdata, `CTB_MASK_RAMP);
			end
		end

		if (cmd_read) begin
			next_cur.rvalid = 1'b1;
			next_cur.hit = 1'b1;
			if (cmd_code == `CTB_OFS_THRESHOLDS) begin
				next_cur.rdata = cur.thresholds;
			end else if (cmd_code == `CTB_OFS_MAX_CURRENT) begin
				next_cur.rdata = cur.max_current;
			end else if (cmd_code == `CTB_OFS_BOOT_CODE) begin
				next_cur.rdata = cur.boot_code;
			end else if (cmd_code == `CTB_OFS_FREQ_SOFT) begin
				next_cur.rdata = cur.freq_soft;
			end else if (cmd_code == `CTB_OFS_SLEW_MODES) begin
				next_cur.rdata = cur.slew_modes;
			end else if (cmd_code == `CTB_OFS_RAMP) begin
				next_cur.rdata = cur.ramp;
			end else begin
				next_cur.rdata = 8'h00;
				next_cur.hit = 1'b0;
			end
		end

		next_cur.usr_mv = dec_usr_mv;
		next_cur.usr_on = dec_usr_on;
		next_cur.osr_mv = dec_osr_mv;
		next_cur.osr_on = dec_osr_on;
		next_cur.freq = dec_freq;
		next_cur.slew = dec_slew;
		next_cur.soft_slew = dec_soft_slew;
		next_cur.ramp_pp = dec_ramp;
		next_cur.boot_target = dec_boot;
		// Registered so the ready output comes straight from a flop
		next_cur.ready = next_cur.phase == CTB_RUN;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign cmd_rdata = cur.rdata;
	assign cmd_rvalid = cur.rvalid;
	assign cmd_hit = cur.hit;
	assign config_ready = cur.ready;
	assign undershoot_cut_threshold = cur.thresholds[`CTB_USR_HI:`CTB_USR_LO];
	assign overshoot_cut_threshold = cur.thresholds[`CTB_OSR_HI:`CTB_OSR_LO];
	assign max_current_amps = cur.max_current;
	assign boot_voltage_code = cur.boot_code;
	assign switching_frequency_select = cur.freq_soft[`CTB_FSW_HI:`CTB_FSW_LO];
	assign soft_start_rise_scale = cur.freq_soft[`CTB_RISE_HI:`CTB_RISE_LO];
	assign vid_table_select = cur.slew_modes[`CTB_BIT_VID_TABLE];
	assign interleave_pairing_select = cur.slew_modes[`CTB_BIT_PAIRING];
	assign phase_shedding_enable = cur.slew_modes[`CTB_BIT_SHEDDING];
	assign zero_load_line_select = cur.slew_modes[`CTB_BIT_ZERO_LL];
	assign ramp_amplitude_select = cur.ramp[`CTB_RAMP_HI:`CTB_RAMP_LO];
	assign undershoot_mv = cur.usr_mv;
	assign undershoot_on = cur.usr_on;
	assign overshoot_mv = cur.osr_mv;
	assign overshoot_on = cur.osr_on;
	assign freq_khz = cur.freq;
	assign slew_rate = cur.slew;
	assign soft_start_slew = cur.soft_slew;
	assign ramp_mv = cur.ramp_pp;
	assign boot_mv = cur.boot_target;

	default clocking chk_clk @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_usr_off_code: assert property (
		cur.thresholds[6:4] == 3'h7 |=> !undershoot_on && undershoot_mv == 8'h00)
		else $error("undershoot cut not disabled by code 7");

	// Decoded outputs hold reset zeros only until the first edge after release
	chk_osr_map_low: assert property (
		config_ready && cur.thresholds[2:0] == 3'h0 |=> overshoot_on && overshoot_mv == 8'h1e)
		else $error("overshoot code 0 not 30 mV");

	chk_write_max_current_amps: assert property (
		config_ready && cmd_write && cmd_code == 8'hda |=> max_current_amps == $past(cmd_wdata))
		else $error("max current write not stored");

	chk_nvm_defaults: assert property (
		cur.phase == CTB_APPLY && s_nvm |=> vid_table_select && boot_voltage_code == 8'h97
			&& max_current_amps == 8'h78 && cur.ramp == 8'h06)
		else $error("non-volatile defaults not loaded");

	chk_freq_top: assert property (
		cur.freq_soft[7:4] == 4'hf |=> freq_khz == 10'h3e8)
		else $error("frequency code 15 not 1000 kHz");

	chk_fast_slew_add: assert property (
		config_ready && fast_slew_enable && cur.slew_modes[2:0] == 3'h0 |=> slew_rate == 10'h0aa)
		else $error("fast slew not adding 1.36 mV/us");

	chk_soft_eighth: assert property (
		soft_start_rise_scale == 2'h3 ##1 soft_start_rise_scale == 2'h3
			|-> soft_start_slew == (slew_rate >> 3))
		else $error("soft start not an eighth of slew");

	chk_ramp_top: assert property (
		cur.ramp[2:0] == 3'h7 |=> ramp_mv == 8'hc8)
		else $error("ramp code 7 not 200 mV");

	chk_reserved_zero: assert property (
		cur.thresholds[7] == 1'b0 && cur.thresholds[3] == 1'b0
			&& cur.freq_soft[3:2] == 2'h0 && cur.ramp[7:3] == 5'h00)
		else $error("reserved bit reads nonzero");

	chk_read_answer: assert property (
		cmd_read && cmd_code == 8'hdb |=> cmd_rvalid && cmd_hit
			&& cmd_rdata == $past(boot_voltage_code))
		else $error("boot code read-back wrong");

	chk_bit5_inert: assert property (
		config_ready && $stable(cur.slew_modes[4:0]) && $stable(cur.slew_modes[7:6])
			&& $stable(fast_slew_enable) |=> $stable(slew_rate))
		else $error("unused mode bit changed behaviour");

	cov_nvm_boot: cover property (cur.phase == CTB_APPLY && s_nvm);
	cov_strap_boot: cover property (cur.phase == CTB_APPLY && !s_nvm);
	cov_host_override: cover property (config_ready && cmd_write && cmd_code == 8'hdd);
	cov_unmapped_read: cover property (cmd_rvalid && !cmd_hit);

endmodule // ctb_config_bank
`default_nettype wire

/* tb/ctb_host_model.sv */
// Host model that issues single-byte command cycles to the tuning bank
`timescale 1ns/1ps
`default_nettype none

module ctb_host_model import ctb_pkg::*; (
	// Clock
	input wire logic clk,
	// Command port toward the bank
	output logic [7:0] cmd_code,
	output logic cmd_write,
	output logic cmd_read,
	output logic [7:0] cmd_wdata,
	input wire logic [7:0] cmd_rdata,
	input wire logic cmd_rvalid,
	input wire logic cmd_hit
);
	initial begin
		cmd_code = 8'h00;
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		cmd_wdata = 8'h00;
	end

	// Idle lines carry the inverse, so a stale code never passes for a live one
	task automatic write_reg(input ctb_byte_type code, input ctb_byte_type data);
		@(posedge clk);
		cmd_write <= 1'b1;
		cmd_code <= code;
		cmd_wdata <= data;
		@(posedge clk);
		cmd_write <= 1'b0;
		cmd_code <= ~code;
		cmd_wdata <= ~data;
	endtask

	// Answer is registered at the taking edge; rvalid and hit stand only one cycle, rdata holds
	task automatic read_reg(input ctb_byte_type code, output ctb_byte_type data,
		output logic hit, output logic valid);
		@(posedge clk);
		cmd_read <= 1'b1;
		cmd_code <= code;
		@(posedge clk);
		cmd_read <= 1'b0;
		cmd_code <= ~code;
		#1;
		data = cmd_rdata;
		hit = cmd_hit;
		valid = cmd_rvalid;
	endtask
endmodule // ctb_host_model

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the converter tuning bank
`timescale 1ns/1ps
`default_nettype none
`include "ctb_defines.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
	$display("Error %s expected %0h seen %0h", nm, ex, got); end end

module tb import ctb_pkg::*;;
	logic clk, resetn, use_nvm_defaults, fast_slew_enable;
	logic [7:0] strap_thresholds, freq_current_strap_pin_max_current_amps, freq_current_strap_pin_freq;
	logic [7:0] strap_boot_code, strap_slew_modes, current_limit_ramp_strap_pin;
	logic [7:0] cmd_code, cmd_wdata, cmd_rdata;
	logic cmd_write, cmd_read, cmd_rvalid, cmd_hit, config_ready;
	logic [2:0] undershoot_cut_threshold, overshoot_cut_threshold, ramp_amplitude_select;
	logic [7:0] max_current_amps, boot_voltage_code;
	logic [3:0] switching_frequency_select;
	logic [1:0] soft_start_rise_scale;
	logic vid_table_select, interleave_pairing_select, phase_shedding_enable;
	logic zero_load_line_select, undershoot_on, overshoot_on;
	logic [7:0] undershoot_mv, overshoot_mv, ramp_mv;
	logic [9:0] freq_khz, slew_rate, soft_start_slew;
	logic [11:0] boot_mv;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	ctb_byte_type rd;
	logic hit, vld;
	logic [2:0] c3;
	logic [3:0] f4;
	int us_t[8] = '{20, 30, 60, 80, 100, 120, 140, 0};
	int os_t[8] = '{30, 40, 60, 80, 100, 120, 140, 0};
	int rp_t[8] = '{20, 40, 60, 80, 100, 120, 150, 200};
	// Slew in 10 uV/us units; code 3 is the designer's fill-in
	int sl_t[8] = '{34, 68, 102, 136, 170, 204, 238, 274};
	int fc_t[4] = '{0, 1, 8, 15};
	int fk_t[4] = '{300, 400, 350, 1000};

	ctb_config_bank uut (.clk, .resetn, .use_nvm_defaults, .strap_thresholds,
		.freq_current_strap_pin_max_current_amps, .freq_current_strap_pin_freq, .strap_boot_code,
		.strap_slew_modes, .current_limit_ramp_strap_pin, .fast_slew_enable, .cmd_code,
		.cmd_write, .cmd_read, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_hit, .config_ready,
		.undershoot_cut_threshold, .overshoot_cut_threshold, .max_current_amps,
		.boot_voltage_code, .switching_frequency_select, .soft_start_rise_scale,
		.vid_table_select, .interleave_pairing_select, .phase_shedding_enable,
		.zero_load_line_select, .ramp_amplitude_select, .undershoot_mv, .undershoot_on,
		.overshoot_mv, .overshoot_on, .freq_khz, .slew_rate, .soft_start_slew, .ramp_mv,
		.boot_mv);

	ctb_host_model host (.clk, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata, .cmd_rdata,
		.cmd_rvalid, .cmd_hit);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			results();
		end
	end

	task automatic chk_rd(input ctb_byte_type code, input ctb_byte_type ex, input logic ex_hit);
		host.read_reg(code, rd, hit, vld);
		`CHK("rvalid", 1'b1, vld);
		`CHK("rdata", ex, rd);
		`CHK("hit", ex_hit, hit);
	endtask

	// A write is issued before the defaults land; it must be dropped
	task automatic do_reset(input logic nvm);
		@(posedge clk);
		resetn <= 1'b0;
		use_nvm_defaults <= nvm;
		repeat (5) @(posedge clk);
		#1;
		`CHK("ready in reset", 1'b0, config_ready);
		`CHK("max_current_amps in reset", 8'h00, max_current_amps);
		@(posedge clk);
		resetn <= 1'b1;
		host.write_reg(`CTB_OFS_MAX_CURRENT, 8'h55);
		for (int i = 0; i < 20 && config_ready !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK("ready", 1'b1, config_ready);
	endtask

	initial begin
		resetn = 1'b0;
		use_nvm_defaults = 1'b0;
		fast_slew_enable = 1'b0;
		strap_thresholds = 8'hb5;
		freq_current_strap_pin_max_current_amps = 8'h3c;
		freq_current_strap_pin_freq = 8'hfe;
		strap_boot_code = 8'h41;
		strap_slew_modes = 8'h52;
		current_limit_ramp_strap_pin = 8'hfd;
		do_reset(1'b0);
		`CHK("early write", 8'h3c, max_current_amps);
		chk_rd(`CTB_OFS_THRESHOLDS, 8'h35, 1'b1);
		chk_rd(`CTB_OFS_MAX_CURRENT, 8'h3c, 1'b1);
		chk_rd(`CTB_OFS_BOOT_CODE, 8'h41, 1'b1);
		chk_rd(`CTB_OFS_FREQ_SOFT, 8'hf2, 1'b1);
		chk_rd(`CTB_OFS_SLEW_MODES, 8'h52, 1'b1);
		chk_rd(`CTB_OFS_RAMP, 8'h05, 1'b1);
		chk_rd(8'hdf, 8'h00, 1'b0);
		for (int c = 0; c < 8; c++) begin
			c3 = c[2:0];
			host.write_reg(`CTB_OFS_THRESHOLDS, {1'b1, c3, 1'b1, c3});
			chk_rd(`CTB_OFS_THRESHOLDS, {1'b0, c3, 1'b0, c3}, 1'b1);
			`CHK("us code", c3, undershoot_cut_threshold);
			`CHK("us on", c3 != 3'h7, undershoot_on);
			`CHK("us mv", us_t[c], undershoot_mv);
			`CHK("os code", c3, overshoot_cut_threshold);
			`CHK("os on", c3 != 3'h7, overshoot_on);
			`CHK("os mv", os_t[c], overshoot_mv);
			host.write_reg(`CTB_OFS_RAMP, {5'h1f, c3});
			chk_rd(`CTB_OFS_RAMP, {5'h00, c3}, 1'b1);
			`CHK("ramp mv", rp_t[c], ramp_mv);
			`CHK("ramp code", c3, ramp_amplitude_select);
			@(posedge clk);
			fast_slew_enable <= c3[0];
			host.write_reg(`CTB_OFS_SLEW_MODES, {c3, c3[1:0], c3});
			chk_rd(`CTB_OFS_SLEW_MODES, {c3, c3[1:0], c3}, 1'b1);
			`CHK("table", c3[2], vid_table_select);
			`CHK("pairing", c3[1], interleave_pairing_select);
			`CHK("shedding", c3[1], phase_shedding_enable);
			`CHK("zero ll", c3[0], zero_load_line_select);
			`CHK("slew", sl_t[c] + (c3[0] ? 136 : 0), slew_rate);
		end
		// Slew now 2.74 plus the fast-slew step
		for (int i = 0; i < 4; i++) begin
			f4 = fc_t[i][3:0];
			host.write_reg(`CTB_OFS_FREQ_SOFT, {f4, 2'h3, i[1:0]});
			chk_rd(`CTB_OFS_FREQ_SOFT, {f4, 2'h0, i[1:0]}, 1'b1);
			`CHK("fsw", f4, switching_frequency_select);
			`CHK("rise", i[1:0], soft_start_rise_scale);
			`CHK("freq", fk_t[i], freq_khz);
			`CHK("soft slew", 410 >> i, soft_start_slew);
		end
		host.write_reg(`CTB_OFS_MAX_CURRENT, 8'hff);
		chk_rd(`CTB_OFS_MAX_CURRENT, 8'hff, 1'b1);
		host.write_reg(`CTB_OFS_BOOT_CODE, 8'h97);
		chk_rd(`CTB_OFS_BOOT_CODE, 8'h97, 1'b1);
		`CHK("boot code", 8'h97, boot_voltage_code);
		`CHK("boot old", 12'd1000, boot_mv);
		host.write_reg(`CTB_OFS_SLEW_MODES, 8'h00);
		chk_rd(`CTB_OFS_SLEW_MODES, 8'h00, 1'b1);
		`CHK("boot new", 12'd2000, boot_mv);
		do_reset(1'b1);
		chk_rd(`CTB_OFS_THRESHOLDS, 8'h77, 1'b1);
		chk_rd(`CTB_OFS_MAX_CURRENT, 8'h78, 1'b1);
		chk_rd(`CTB_OFS_BOOT_CODE, 8'h97, 1'b1);
		chk_rd(`CTB_OFS_FREQ_SOFT, 8'h20, 1'b1);
		chk_rd(`CTB_OFS_SLEW_MODES, 8'h89, 1'b1);
		chk_rd(`CTB_OFS_RAMP, 8'h06, 1'b1);
		results();
	end
endmodule // tb

`default_nettype wire
